// ===== src/fbd_pkg.sv
// constants, types and state encodings shared by the flash boot and download sequencer
// Functional notes
// - boot mode: erase all user and user boot arrays after inquiry, before commands
// - program start address then data; all-ones address returns to command wait
// - erase block numbers follow erase command; block all-ones returns to command wait
// - memory read allowed only after the automatic full erase finished
// - user program mode: user boot array stays write protected
// - one programming unit is 128 bytes; larger images repeat with advanced address
// - program select bit picks the built-in routine; target register gives destination
// - more than one program selected: skip copy, set select error in result
// - request bit set only while unlock key holds the download code
// - request bit set only by a write executed from on-chip RAM
// - download clears request bit and both select registers before returning
// - order: map embedded store, check and copy, write result, map back
// - cpu general registers unchanged across the download
// - interrupts held during download and released on return
// - key error bit is 0 for a correct key, 1 otherwise
package fbd_pkg;

    // ************************************************************
    // codes and terminators
    // ************************************************************
    localparam logic [27:0] PROG_END_ADDR  = 28'hfffffff;
    localparam logic [7:0]  ERASE_END_BLK  = 8'hff;
    localparam logic [7:0]  KEY_DL_CODE    = 8'ha5;
    localparam logic [7:0]  KEY_RESET      = 8'h00;
    localparam logic [7:0]  CMD_PROG       = 8'h43;  // host command codes
    localparam logic [7:0]  CMD_ERASE      = 8'h48;
    localparam logic [6:0]  UNIT_LAST      = 7'h7f;  // 128-byte unit
    localparam logic [7:0]  DL_LAST        = 8'h3f;  // last byte index of the 64-byte embedded routine image
    localparam logic [15:0] ADDR_ZERO      = 16'h0000;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int          CLK_PERIOD_NS  = 25;
    localparam int          ERASE_ALL_NS   = 2000;
    localparam int          ERASE_ALL_CYC  = (ERASE_ALL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0]  ERASE_ALL_LAST = 8'(ERASE_ALL_CYC - 1);

    // ************************************************************
    // types
    // ************************************************************
    typedef struct packed {
        logic [4:0] rsvd;
        logic       ss;     // selection error
        logic       fk;     // key error
        logic       sf;     // overall fail
    } fbd_result_t;

    typedef struct packed {
        logic        cmd_valid;
        logic [7:0]  cmd_code;
        logic        addr_valid;
        logic [27:0] addr;
        logic        data_valid;
        logic [7:0]  data;
        logic        blk_valid;
        logic [7:0]  blk;
    } fbd_host_t;

    typedef struct packed {
        logic       key_we;
        logic [7:0] key_data;
        logic       sel_we;
        logic       prog_sel;
        logic       erase_sel;
        logic       req_we;
        logic       req_data;
        logic       from_ram;
        logic [7:0] target;
    } fbd_cpu_wr_t;

    typedef enum logic [2:0] {B_OFF, B_INQ, B_ERASE, B_CMD, B_PADDR, B_PDATA, B_BLK} fbd_boot_t;
    typedef enum logic [2:0] {DL_IDLE, DL_MAP, DL_COPY, DL_RESULT, DL_UNMAP} fbd_dl_t;

endpackage

// ===== src/fbd_key_check.sv
// unlock key register with its combinational compare
`timescale 1ns/1ps
module fbd_key_check
    import fbd_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       we,
    input  wire logic [7:0] wdata,
    output logic      [7:0] key,
    output logic            unlocked
);

    // key storage, protected state after reset
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            key <= KEY_RESET;
        end else if (we) begin
            key <= wdata;
        end
    end

    // compared every cycle, no latency on the request path
    assign unlocked = (key == KEY_DL_CODE);

endmodule

// ===== src/fbd_seq.sv
// flash boot-mode command sequencer and user-mode download controller
`timescale 1ns/1ps
module fbd_seq
    import fbd_pkg::*;
(
    input  wire logic        CORE_CLK,
    input  wire logic        RST_N,
    input  wire logic        BOOT_MODE,
    input  wire logic        INQ_DONE,
    input  wire fbd_host_t   HOST,
    input  wire fbd_cpu_wr_t CPU,
    output logic             ERASE_ALL_BUSY,
    output logic             READ_ALLOWED,
    output logic             CMD_READY,
    output logic             PROG_WE,
    output logic [27:0]      PROG_ADDR,
    output logic [7:0]       PROG_DATA,
    output logic             ERASE_BLK_REQ,
    output logic [7:0]       ERASE_BLK_NUM,
    output logic             USER_BOOT_WP,
    output logic [7:0]       KEY_VALUE,
    output logic             REQ_BIT,
    output logic             PROG_SEL,
    output logic             ERASE_SEL,
    output logic             ARRAY_EMBEDDED,
    output logic             CPU_HOLD,
    output logic             IRQ_HOLD,
    output logic             COPY_WE,
    output logic [15:0]      COPY_ADDR,
    output logic             RESULT_WE,
    output fbd_result_t      RESULT_DATA
);

    // ************************************************************
    // mode pin synchroniser and key register
    // ************************************************************
    logic        bm_meta;
    logic        bm_sync;
    logic        unlocked;
    fbd_boot_t   bst;
    fbd_dl_t     dst;
    logic [7:0]  erase_cnt;
    logic [27:0] prog_base;
    logic [6:0]  byte_cnt;
    logic [7:0]  dl_cnt;
    logic [15:0] dl_base;
    logic        sel_err;
    logic        key_err;
    logic        req_accept;

    // mode pin comes from outside, two stages before use
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            bm_meta <= 1'b0;
            bm_sync <= 1'b0;
        end else begin
            bm_meta <= BOOT_MODE;
            bm_sync <= bm_meta;
        end
    end

    fbd_key_check u_key (
        .clk      (CORE_CLK),
        .rst_n    (RST_N),
        .we       (CPU.key_we && dst == DL_IDLE),
        .wdata    (CPU.key_data),
        .key      (KEY_VALUE),
        .unlocked (unlocked)
    );

    // user boot array protected whenever not in boot mode
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            USER_BOOT_WP <= 1'b1;
        end else begin
            USER_BOOT_WP <= !bm_sync;
        end
    end

    // ************************************************************
    // boot-mode command sequencer
    // ************************************************************
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            bst            <= B_OFF;
            erase_cnt      <= 8'h00;
            prog_base      <= 28'h0000000;
            byte_cnt       <= 7'h00;
            ERASE_ALL_BUSY <= 1'b0;
            READ_ALLOWED   <= 1'b0;
            CMD_READY      <= 1'b0;
            PROG_WE        <= 1'b0;
            PROG_ADDR      <= 28'h0000000;
            PROG_DATA      <= 8'h00;
            ERASE_BLK_REQ  <= 1'b0;
            ERASE_BLK_NUM  <= 8'h00;
        end else begin
            PROG_WE       <= 1'b0;
            ERASE_BLK_REQ <= 1'b0;
            unique case (bst)
                B_OFF: begin
                    if (bm_sync) begin
                        bst <= B_INQ;
                    end
                end
                B_INQ: begin
                    // no command taken until the whole array is blank
                    if (INQ_DONE) begin
                        bst            <= B_ERASE;
                        erase_cnt      <= 8'h00;
                        ERASE_ALL_BUSY <= 1'b1;
                    end
                end
                B_ERASE: begin
                    if (erase_cnt == ERASE_ALL_LAST) begin
                        bst            <= B_CMD;
                        ERASE_ALL_BUSY <= 1'b0;
                        READ_ALLOWED   <= 1'b1;
                        CMD_READY      <= 1'b1;
                    end else begin
                        erase_cnt <= erase_cnt + 8'h01;
                    end
                end
                B_CMD: begin
                    if (HOST.cmd_valid && HOST.cmd_code == CMD_PROG) begin
                        bst       <= B_PADDR;
                        CMD_READY <= 1'b0;
                    end else if (HOST.cmd_valid && HOST.cmd_code == CMD_ERASE) begin
                        bst       <= B_BLK;
                        CMD_READY <= 1'b0;
                    end
                end
                B_PADDR: begin
                    if (HOST.addr_valid && HOST.addr == PROG_END_ADDR) begin
                        bst       <= B_CMD;
                        CMD_READY <= 1'b1;
                    end else if (HOST.addr_valid) begin
                        bst       <= B_PDATA;
                        prog_base <= HOST.addr;
                        byte_cnt  <= 7'h00;
                    end
                end
                B_PDATA: begin
                    // one unit is exactly 128 bytes, then a new address
                    if (HOST.data_valid) begin
                        PROG_WE   <= 1'b1;
                        PROG_ADDR <= prog_base + {21'h000000, byte_cnt};
                        PROG_DATA <= HOST.data;
                        byte_cnt  <= byte_cnt + 7'h01;
                        if (byte_cnt == UNIT_LAST) begin
                            bst <= B_PADDR;
                        end
                    end
                end
                B_BLK: begin
                    if (HOST.blk_valid && HOST.blk == ERASE_END_BLK) begin
                        bst       <= B_CMD;
                        CMD_READY <= 1'b1;
                    end else if (HOST.blk_valid) begin
                        ERASE_BLK_REQ <= 1'b1;
                        ERASE_BLK_NUM <= HOST.blk;
                    end
                end
                default: bst <= B_OFF;
            endcase
        end
    end

    // ************************************************************
    // download request and select registers
    // ************************************************************
    // key and fetch origin both gate the set; other writes are lost
    assign req_accept = CPU.req_we && CPU.req_data && unlocked
                        && CPU.from_ram && dst == DL_IDLE && !bm_sync;

    // request bit only lives while the cpu is held, so it never reads as one
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            REQ_BIT <= 1'b0;
        end else if (dst == DL_UNMAP) begin
            REQ_BIT <= 1'b0;
        end else if (req_accept) begin
            REQ_BIT <= 1'b1;
        end
    end

    // selects frozen while downloading, cleared on the way out
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            PROG_SEL  <= 1'b0;
            ERASE_SEL <= 1'b0;
        end else if (dst == DL_UNMAP) begin
            PROG_SEL  <= 1'b0;
            ERASE_SEL <= 1'b0;
        end else if (CPU.sel_we && dst == DL_IDLE) begin
            PROG_SEL  <= CPU.prog_sel;
            ERASE_SEL <= CPU.erase_sel;
        end
    end

    // ************************************************************
    // download sequencer
    // ************************************************************
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            dst            <= DL_IDLE;
            dl_cnt         <= 8'h00;
            dl_base        <= ADDR_ZERO;
            sel_err        <= 1'b0;
            key_err        <= 1'b0;
            ARRAY_EMBEDDED <= 1'b0;
            CPU_HOLD       <= 1'b0;
            IRQ_HOLD       <= 1'b0;
            COPY_WE        <= 1'b0;
            COPY_ADDR      <= ADDR_ZERO;
            RESULT_WE      <= 1'b0;
            RESULT_DATA    <= '0;
        end else begin
            COPY_WE   <= 1'b0;
            RESULT_WE <= 1'b0;
            unique case (dst)
                DL_IDLE: begin
                    if (req_accept) begin
                        dst            <= DL_MAP;
                        dl_base        <= {CPU.target, 8'h00};
                        ARRAY_EMBEDDED <= 1'b1;
                        CPU_HOLD       <= 1'b1;
                        IRQ_HOLD       <= 1'b1;
                    end
                end
                DL_MAP: begin
                    sel_err <= PROG_SEL && ERASE_SEL;
                    key_err <= !unlocked;
                    dl_cnt  <= 8'h00;
                    // nothing copied on a double or empty selection
                    if (PROG_SEL != ERASE_SEL) begin
                        dst <= DL_COPY;
                    end else begin
                        dst <= DL_RESULT;
                    end
                end
                DL_COPY: begin
                    COPY_WE   <= 1'b1;
                    COPY_ADDR <= dl_base + {8'h00, dl_cnt};
                    dl_cnt    <= dl_cnt + 8'h01;
                    if (dl_cnt == DL_LAST) begin
                        dst <= DL_RESULT;
                    end
                end
                DL_RESULT: begin
                    // result goes last so it overwrites the image's first byte
                    RESULT_WE        <= 1'b1;
                    COPY_ADDR        <= dl_base;
                    RESULT_DATA      <= '0;
                    RESULT_DATA.ss   <= sel_err;
                    RESULT_DATA.fk   <= key_err;
                    RESULT_DATA.sf   <= sel_err || key_err;
                    dst              <= DL_UNMAP;
                end
                DL_UNMAP: begin
                    ARRAY_EMBEDDED <= 1'b0;
                    CPU_HOLD       <= 1'b0;
                    IRQ_HOLD       <= 1'b0;
                    dst            <= DL_IDLE;
                end
                default: dst <= DL_IDLE;
            endcase
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);

    sequence s_result_out;
        RESULT_WE && ARRAY_EMBEDDED && CPU_HOLD;
    endsequence
    sequence s_unmapped;
        !ARRAY_EMBEDDED && !CPU_HOLD && !IRQ_HOLD && !REQ_BIT;
    endsequence

    property p_erase_first;
        CMD_READY |-> READ_ALLOWED && !ERASE_ALL_BUSY;
    endproperty
    a_erase_first: assert property (p_erase_first) else $error("command wait before full erase");

    property p_addr_end;
        bst == B_PADDR && HOST.addr_valid && HOST.addr == PROG_END_ADDR |=> CMD_READY && bst == B_CMD;
    endproperty
    a_addr_end: assert property (p_addr_end) else $error("terminator address not honoured");

    property p_blk_end;
        bst == B_BLK && HOST.blk_valid && HOST.blk == ERASE_END_BLK |=> CMD_READY && !ERASE_BLK_REQ;
    endproperty
    a_blk_end: assert property (p_blk_end) else $error("terminator block not honoured");

    property p_unit_end;
        bst == B_PDATA && HOST.data_valid && byte_cnt == UNIT_LAST |=> PROG_WE && bst == B_PADDR;
    endproperty
    a_unit_end: assert property (p_unit_end) else $error("unit length wrong");

    property p_boot_wp;
        ##1 (USER_BOOT_WP == !$past(bm_sync));
    endproperty
    a_boot_wp: assert property (p_boot_wp) else $error("user boot protect wrong");

    property p_sel_err;
        dst == DL_MAP && PROG_SEL && ERASE_SEL |-> ##1 !COPY_WE ##1 (RESULT_WE && RESULT_DATA.ss);
    endproperty
    a_sel_err: assert property (p_sel_err) else $error("double selection not reported");

    property p_key_gate;
        !REQ_BIT && CPU.req_we && (!unlocked || !CPU.from_ram) |=> !REQ_BIT;
    endproperty
    a_key_gate: assert property (p_key_gate) else $error("request set without key or from flash");

    property p_clear_out;
        $fell(REQ_BIT) |-> !PROG_SEL && !ERASE_SEL && !CPU_HOLD;
    endproperty
    a_clear_out: assert property (p_clear_out) else $error("selects not cleared on return");

    property p_order;
        s_result_out |=> s_unmapped;
    endproperty
    a_order: assert property (p_order) else $error("map back not after result");

    property p_hold;
        (COPY_WE || RESULT_WE || REQ_BIT) |-> ARRAY_EMBEDDED && CPU_HOLD && IRQ_HOLD;
    endproperty
    a_hold: assert property (p_hold) else $error("cpu or interrupts not held");

    property p_unlock;
        $rose(REQ_BIT) |-> $past(KEY_VALUE) == KEY_DL_CODE && $past(unlocked) && $past(CPU.from_ram);
    endproperty
    a_unlock: assert property (p_unlock) else $error("request set without unlocked key");

endmodule

// ===== test/fbd_host_model.sv
// serial host model that drives the boot-mode command port of the sequencer
`timescale 1ns/1ps
module fbd_host_model
    import fbd_pkg::*;
(
    input  wire logic CORE_CLK,
    output fbd_host_t HOST
);
    // ************************************************************
    // host transfers
    // ************************************************************
    initial HOST = '0;

    // one field as a single-cycle pulse: 0 cmd, 1 addr, 2 data, 3 block
    task automatic pulse(input int f, input logic [27:0] v);
        @(posedge CORE_CLK);
        #2;
        case (f)
            0: begin HOST.cmd_code = v[7:0]; HOST.cmd_valid = 1'b1; end
            1: begin HOST.addr = v; HOST.addr_valid = 1'b1; end
            2: begin HOST.data = v[7:0]; HOST.data_valid = 1'b1; end
            default: begin HOST.blk = v[7:0]; HOST.blk_valid = 1'b1; end
        endcase
        @(posedge CORE_CLK);
        #2;
        HOST.cmd_valid = 1'b0;
        HOST.addr_valid = 1'b0;
        HOST.data_valid = 1'b0;
        HOST.blk_valid = 1'b0;
        // released lines flip, so a stale value never passes for fresh data
        HOST.cmd_code = ~HOST.cmd_code;
        HOST.addr = ~HOST.addr;
        HOST.data = ~HOST.data;
        HOST.blk = ~HOST.blk;
    endtask

    task automatic end_prog();
        pulse(1, PROG_END_ADDR);
    endtask

    task automatic end_erase();
        pulse(3, {20'h0, ERASE_END_BLK});
    endtask
endmodule

// ===== test/fbd_seq_tb.sv
// self-checking bench for the flash boot and download sequencer
`timescale 1ns/1ps
module fbd_seq_tb
    import fbd_pkg::*;
;
    typedef struct {logic [1:0] k; logic [27:0] a; logic [7:0] d; logic [7:0] m;} fbd_exp_t;
    logic        core_clk, rst_n, boot_mode, inq_done;
    fbd_host_t   host;
    fbd_cpu_wr_t cpu;
    logic        erase_all_busy, read_allowed, cmd_ready, prog_we, erase_blk_req, user_boot_wp;
    logic        req_bit, prog_sel, erase_sel, array_embedded, cpu_hold, irq_hold, copy_we, result_we;
    logic [27:0] prog_addr;
    logic [7:0]  prog_data, erase_blk_num, key_value;
    logic [15:0] copy_addr;
    fbd_result_t result_data;
    fbd_exp_t    q[$];
    int          fail_count = 0;
    int          num_checks = 0;
    int          cycles = 0;
    int          n;
    logic [27:0] base;
    logic [7:0]  b;

    // ************************************************************
    // design and host model
    // ************************************************************
    fbd_seq i_fbd_seq (.CORE_CLK(core_clk), .RST_N(rst_n), .BOOT_MODE(boot_mode), .INQ_DONE(inq_done),
        .HOST(host), .CPU(cpu), .ERASE_ALL_BUSY(erase_all_busy), .READ_ALLOWED(read_allowed),
        .CMD_READY(cmd_ready), .PROG_WE(prog_we), .PROG_ADDR(prog_addr), .PROG_DATA(prog_data),
        .ERASE_BLK_REQ(erase_blk_req), .ERASE_BLK_NUM(erase_blk_num), .USER_BOOT_WP(user_boot_wp),
        .KEY_VALUE(key_value), .REQ_BIT(req_bit), .PROG_SEL(prog_sel), .ERASE_SEL(erase_sel),
        .ARRAY_EMBEDDED(array_embedded), .CPU_HOLD(cpu_hold), .IRQ_HOLD(irq_hold), .COPY_WE(copy_we),
        .COPY_ADDR(copy_addr), .RESULT_WE(result_we), .RESULT_DATA(result_data));
    fbd_host_model i_fbd_host_model (.CORE_CLK(core_clk), .HOST(host));

    // 40 MHz clock; cycle ceiling cuts a hang short
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            tally_and_finish();
        end
    end

    task automatic check(input string what, input logic [27:0] seen, input logic [27:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic tick(input int c);
        repeat (c) @(posedge core_clk);
        #2;
    endtask

    // ************************************************************
    // expected-result queue and its watcher
    // ************************************************************
    task automatic take(input logic [1:0] k, input logic [27:0] a, input logic [7:0] d);
        fbd_exp_t e;
        if (q.size() == 0) begin
            check("pending note count", 28'h0, 28'h1);
        end else begin
            e = q.pop_front();
            check("result kind", 28'(k), 28'(e.k));
            check("result address", a, e.a);
            check("result data", 28'(d & e.m), 28'(e.d));
        end
    endtask

    // pulses stand one cycle, so look at them mid-cycle
    always @(negedge core_clk) begin
        if (prog_we === 1'b1) take(2'd0, prog_addr, prog_data);
        if (erase_blk_req === 1'b1) take(2'd1, 28'h0, erase_blk_num);
        if (copy_we === 1'b1 || result_we === 1'b1) begin
            check("array mapped", 28'(array_embedded), 28'h1);
            check("cpu held", 28'(cpu_hold), 28'h1);
            check("irq held", 28'(irq_hold), 28'h1);
        end
        if (copy_we === 1'b1) take(2'd2, 28'(copy_addr), 8'h00);
        if (result_we === 1'b1) take(2'd3, 28'(copy_addr), result_data);
        if (result_we === 1'b1) check("result differs from preset", 28'(result_data == 8'hff), 28'h0);
    end

    // one 128-byte unit; short images padded with all-ones filler
    task automatic prog_unit(input logic [27:0] a, input int len);
        logic [7:0] d;
        i_fbd_host_model.pulse(1, a);
        for (int i = 0; i < 128; i++) begin
            d = (i < len) ? 8'($urandom) : 8'hff;
            q.push_back('{2'd0, a + 28'(i), d, 8'hff});
            i_fbd_host_model.pulse(2, {20'h0, d});
        end
    endtask

    // key, select and request writes, then the download walk
    task automatic download(input logic ps, input logic es, input logic [7:0] key, input logic ram);
        logic [7:0] tgt;
        logic       ok;
        logic       ss;
        tgt = 8'($urandom);
        ok = (key == KEY_DL_CODE) && ram;
        ss = ps & es;
        cpu.key_we = 1'b1;
        cpu.key_data = key;
        tick(1);
        cpu.key_we = 1'b0;
        cpu.sel_we = 1'b1;
        cpu.prog_sel = ps;
        cpu.erase_sel = es;
        tick(1);
        cpu.sel_we = 1'b0;
        check("key value", 28'(key_value), 28'(key));
        if (ok && (ps ^ es))
            for (int i = 0; i < 64; i++) q.push_back('{2'd2, 28'({tgt, 8'h00} + 16'(i)), 8'h00, 8'h00});
        if (ok) q.push_back('{2'd3, 28'({tgt, 8'h00}), {5'h0, ss, 1'b0, ss}, 8'hff});
        cpu.req_we = 1'b1;
        cpu.req_data = 1'b1;
        cpu.from_ram = ram;
        cpu.target = tgt;
        tick(1);
        cpu.req_we = 1'b0;
        check("request bit", 28'(req_bit), 28'(ok));
        check("irq hold", 28'(irq_hold), 28'(ok));
        // cpu stays idle while held: wait up to 200 cycles for the request bit to clear
        for (n = 0; n < 200 && req_bit !== 1'b0; n++) tick(1);
        check("program select", 28'(prog_sel), ok ? 28'h0 : 28'(ps));
        check("erase select", 28'(erase_sel), ok ? 28'h0 : 28'(es));
        check("array mapped back", 28'(array_embedded), 28'h0);
        check("cpu hold", 28'(cpu_hold), 28'h0);
        check("notes left", 28'(q.size()), 28'h0);
        cpu.key_we = 1'b1;
        cpu.key_data = KEY_RESET;
        tick(1);
        cpu.key_we = 1'b0;
        $display("test download %0d%0d done", ps, es);
    endtask

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        rst_n = 1'b0;
        boot_mode = 1'b0;
        inq_done = 1'b0;
        cpu = '0;
        void'($urandom(32'h63be2787));
        tick(16);
        rst_n = 1'b1; // reset never lands mid-program, so no long hold is needed
        check("boot array protect", 28'(user_boot_wp), 28'h1);
        check("key reset", 28'(key_value), 28'h0);
        $display("test reset done");
        boot_mode = 1'b1;
        tick(4);
        inq_done = 1'b1;
        tick(1);
        inq_done = 1'b0;
        tick(3);
        check("erase busy", 28'(erase_all_busy), 28'h1);
        check("read gate", 28'(read_allowed), 28'h0);
        check("boot array open", 28'(user_boot_wp), 28'h0);
        i_fbd_host_model.pulse(0, 28'(CMD_PROG)); // refused while erasing
        check("ready in erase", 28'(cmd_ready), 28'h0);
        for (n = 0; n < 300 && cmd_ready !== 1'b1; n++) tick(1);
        check("ready", 28'(cmd_ready), 28'h1);
        check("read gate", 28'(read_allowed), 28'h1);
        $display("test boot erase done");
        i_fbd_host_model.pulse(0, 28'(CMD_PROG));
        base = {21'($urandom), 7'h00};
        prog_unit(base, 128);
        prog_unit(base + 28'h80, 100);
        i_fbd_host_model.end_prog();
        tick(2);
        check("ready after program", 28'(cmd_ready), 28'h1);
        check("notes left", 28'(q.size()), 28'h0);
        $display("test program done");
        i_fbd_host_model.pulse(0, 28'(CMD_ERASE));
        for (int i = 0; i < 3; i++) begin
            b = 8'($urandom % 255);
            q.push_back('{2'd1, 28'h0, b, 8'hff});
            i_fbd_host_model.pulse(3, {20'h0, b});
        end
        i_fbd_host_model.end_erase();
        tick(2);
        check("ready after erase", 28'(cmd_ready), 28'h1);
        $display("test erase done");
        boot_mode = 1'b0;
        tick(5);
        check("boot array protect", 28'(user_boot_wp), 28'h1);
        download(1'b1, 1'b0, KEY_RESET, 1'b1);
        download(1'b1, 1'b0, KEY_DL_CODE, 1'b0);
        download(1'b1, 1'b0, KEY_DL_CODE, 1'b1);
        download(1'b0, 1'b1, KEY_DL_CODE, 1'b1);
        download(1'b1, 1'b1, KEY_DL_CODE, 1'b1);
        download(1'b0, 1'b0, KEY_DL_CODE, 1'b1);
        tally_and_finish();
    end
endmodule
